// file: cap_sense_range_and_timer_select_test.sv
// Self-checking bench for the sense block
`timescale 1ns/1ns
module cap_sense_range_and_timer_select_test
    import cst_pkg::*;
;
    logic        core_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, cmp_in, cmp_prev;
    logic        run, noise, st_gate_in, load;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd, lfsr_q;
    cst_analog_t analog;
    int          error_cnt, n_checks, edge_cnt, nom;
    // Second timer cases: on, gate enable, gate level, source
    logic [4:0]  st_case [5] = '{5'b00111, 5'b10011, 5'b11011, 5'b11111, 5'b10010};
    logic [7:0]  rst_adr [6] = '{OFF_SENSE_CTL, OFF_ST_CTL, OFF_IRQ_STAT, OFF_IRQ_MASK, OFF_ANALOG, 8'h20};

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    cst_top #(.FT_W(8), .ST_W(16)) DUT (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .cmp_in(cmp_in), .analog(analog), .ft_pin_clk(1'b0), .st_pin_clk(1'b0),
        .st_gate_in(st_gate_in), .irq(irq));
    cst_pad_model u_pad (.core_clk(core_clk), .rst(rst), .analog(analog), .run(run), .noise(noise), .load(load),
        .cmp_in(cmp_in));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // Expected oscillator controls for enable, range and current code
    function automatic logic [7:0] exp_analog(input logic en, input logic rng, input logic [1:0] cur);
        logic on;
        on = en && (rng || cur != CUR_ZERO);
        return {rng, rng, on && cur != CUR_ZERO, on && cur != CUR_ZERO, on, rng, cur};
    endfunction : exp_analog

    // Random source, pad noise and the bench's own edge count
    always @(posedge core_clk) begin
        lfsr_q   <= rst ? 32'h7f11ba2e : lfsr_next(lfsr_q);
        noise    <= lfsr_q[5];
        cmp_prev <= cmp_in;
        if (cmp_in && !cmp_prev) edge_cnt <= edge_cnt + 1;
    end

    // ********
    // Tasks
    // ********
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    // Classic cycle: hold everything until ack is sampled, then release
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            finish_test();
        end
    endtask : wb_cycle
    task automatic rd_chk(input string nm, input logic [7:0] adr, input logic [31:0] exp);
        wb_cycle(1'b0, adr, 32'h0);
        check(nm, exp, rd);
    endtask : rd_chk
    task automatic sense(input logic en, input logic rng, input logic [1:0] cur, input logic pick);
        wb_cycle(1'b1, OFF_SENSE_CTL, {24'h0, en, rng, 2'b00, cur, 1'b0, pick});
    endtask : sense
    // Let the pad oscillate for n cycles, then settle
    task automatic burst(input int n);
        run <= 1'b1;
        repeat (n) @(posedge core_clk);
        run <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : burst

    // ********
    // Main sequence
    // ********
    initial begin
        rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, run, st_gate_in, cmp_prev, load} = 7'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h3;
        wb_dat_i = 32'h0;
        error_cnt = 0;
        n_checks = 0;
        edge_cnt = 0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        foreach (rst_adr[i]) rd_chk("reset value", rst_adr[i], 32'h0);
        wb_cycle(1'b1, OFF_SENSE_CTL, 32'hff);
        rd_chk("sense ctl access", OFF_SENSE_CTL, 32'hcd);
        $display("test registers done");
        for (int m = 0; m < 8; m++) begin
            sense(1'b1, m[2], m[1:0], 1'b0);
            repeat (2) @(posedge core_clk);
            check("analog", 32'(exp_analog(1'b1, m[2], m[1:0])), 32'(analog));
        end
        sense(1'b0, 1'b1, CUR_HIGH, 1'b0);
        repeat (2) @(posedge core_clk);
        check("analog off", 32'(exp_analog(1'b0, 1'b1, CUR_HIGH) & 8'h38), 32'(analog & 8'h38));
        $display("test modes done");
        wb_cycle(1'b1, OFF_OPTION, 32'h0);
        for (int k = 0; k < 3; k++) begin
            sense(k != 2, 1'b0, CUR_MED, k != 1);
            wb_cycle(1'b1, OFF_FT_CNT, 32'h0);
            edge_cnt = 0;
            burst(lfsr_q[6:0] + 8);
            if (k == 0) begin
                sense(1'b1, 1'b0, CUR_HIGH, 1'b1);
                burst(lfsr_q[5:0] + 8);
            end
            rd_chk("first timer count", OFF_FT_CNT, k == 0 ? edge_cnt & 32'hff : 32'h0);
        end
        $display("test first timer done");
        sense(1'b1, 1'b0, CUR_MED, 1'b0);
        for (int k = 0; k < 5; k++) begin
            st_gate_in <= st_case[k][2];
            wb_cycle(1'b1, OFF_ST_CTL, {24'h0, st_case[k][1:0], 4'h0, st_case[k][3], st_case[k][4]});
            wb_cycle(1'b1, OFF_ST_CNT, 32'h0);
            edge_cnt = 0;
            burst(lfsr_q[6:0] + 8);
            rd_chk("second timer count", OFF_ST_CNT, (st_case[k][4] && (!st_case[k][3] || st_case[k][2])
                && st_case[k][1:0] == 2'h3) ? edge_cnt & 32'hffff : 32'h0);
        end
        $display("test second timer done");
        // Time base from a bench loop, the same length unloaded and loaded
        wb_cycle(1'b1, OFF_ST_CTL, 32'hc1);
        for (int l = 0; l < 2; l++) begin
            load <= l[0];
            wb_cycle(1'b1, OFF_ST_CNT, 32'h0);
            edge_cnt = 0;
            burst(64);
            rd_chk("load count", OFF_ST_CNT, edge_cnt);
            if (l == 0) nom = rd;
        end
        check("touch below midway", 32'h1, {31'h0, rd < (nom + rd) / 2});
        // Toggle gate opens for one full first timer period of 256 cycles,
        // which holds 64 pad periods of 4 cycles
        load <= 1'b0;
        wb_cycle(1'b1, OFF_ST_CTL, 32'hc7);
        wb_cycle(1'b1, OFF_ST_CNT, 32'h0);
        wb_cycle(1'b1, OFF_OPTION, 32'h1);
        wb_cycle(1'b1, OFF_FT_CNT, 32'h0);
        burst(600);
        rd_chk("gated count", OFF_ST_CNT, 32'h40);
        wb_cycle(1'b1, OFF_OPTION, 32'h0);
        rd_chk("first overflow", OFF_IRQ_STAT, 32'h1 << IRQ_FT_OVF);
        $display("test time base done");
        wb_cycle(1'b1, OFF_ST_CTL, 32'h0);
        wb_cycle(1'b1, OFF_IRQ_MASK, 32'h0);
        sense(1'b1, 1'b1, CUR_ZERO, 1'b0);
        wb_cycle(1'b0, OFF_IRQ_STAT, 32'h0);
        burst(40);
        check("irq masked", 32'h0, {31'h0, irq});
        wb_cycle(1'b1, OFF_IRQ_MASK, 32'h1 << IRQ_NOISE);
        @(posedge core_clk);
        check("irq", 32'h1, {31'h0, irq});
        rd_chk("noise status", OFF_IRQ_STAT, 32'h1 << IRQ_NOISE);
        @(posedge core_clk);
        check("irq cleared", 32'h0, {31'h0, irq});
        $display("test noise done");
        finish_test();
    end
endmodule : cap_sense_range_and_timer_select_test

// file: cst_checker.sv
// Port assertions for the sense block, bound to its top
`timescale 1ns/1ns
module cst_checker
    import cst_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Bus handshake
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_ack_o,
    // Oscillator controls
    input  wire cst_analog_t analog
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // ********
    // Reference and current steering
    // ********
    a_upper_ref_pick: assert property (analog.upper_ref == (analog.range_high ? HI_REF_FVR : HI_REF_VDD))
        else $error("upper threshold does not follow range");
    a_lower_ref_pick: assert property (analog.lower_ref == (analog.range_high ? LO_REF_DAC : LO_REF_GND))
        else $error("lower threshold does not follow range");
    a_noise_no_drive: assert property (analog.range_high && analog.level == CUR_ZERO |-> !analog.source_en && !analog.sink_en)
        else $error("current flows in noise detection");
    a_off_all_dark: assert property (!analog.range_high && analog.level == CUR_ZERO |-> !analog.cmp_en && !analog.source_en)
        else $error("oscillator alive in off mode");
    a_level_drives: assert property (analog.cmp_en && analog.level != CUR_ZERO |-> analog.source_en && analog.sink_en)
        else $error("current code gives no drive");
    a_drive_needs_cmp: assert property (analog.source_en || analog.sink_en |-> analog.cmp_en)
        else $error("drive without comparator");
    // ********
    // Bus answer timing
    // ********
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    // Main scenarios reached
    c_noise_mode: cover property (analog.range_high && analog.level == CUR_ZERO && analog.cmp_en);
    c_drive_high: cover property (analog.range_high && analog.source_en);
    c_bus_answer: cover property (wb_cyc_i && wb_stb_i ##1 wb_ack_o);
endmodule : cst_checker

bind cst_top cst_checker u_chk (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .analog(analog));

// file: cst_osc.sv
// Shared constants and types of the sense block, plus the oscillator control leaf
// What this block does
// - A set reference range select bit picks the variable references, a clear one the internal fixed references.
// - With fixed references the lower threshold is ground and the upper threshold is the supply.
// - With variable references the lower threshold is the DAC output and the upper is the fixed reference unit.
// - The current range field gives 00 zero current, 01 low, 10 medium and 11 high within each range.
// - Code 00 means off in the low range and noise detection in the high range.
// - Noise detection stops sourcing and sinking on the sense pin but keeps the comparators running.
// - In noise detection, pin noise toggles the comparator output so that pin activity can be counted.
// - The oscillator clocks the first timer when the sense clock pick is set and its clock source bit is clear.
// - The oscillator clocks the second timer when its clock source field holds 11.
// - The second timer is off with its on bit 0, free running with on 1 and gate enable 0, gated with both 1.
// - Oscillator edges reach the timer only while the module enable is set, and it runs on in low power.
`timescale 1ns/1ns

package cst_pkg;

    // ****************************************************************
    // Register map, byte addresses on a 32-bit Wishbone bus
    // ****************************************************************
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  OFF_SENSE_CTL = 8'h00;
    localparam logic [7:0]  OFF_OPTION    = 8'h04;
    localparam logic [7:0]  OFF_ST_CTL    = 8'h08;
    localparam logic [7:0]  OFF_FT_CNT    = 8'h0c;
    localparam logic [7:0]  OFF_ST_CNT    = 8'h10;
    localparam logic [7:0]  OFF_IRQ_STAT  = 8'h14;
    localparam logic [7:0]  OFF_IRQ_MASK  = 8'h18;
    localparam logic [7:0]  OFF_ANALOG    = 8'h1c;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int          SC_EN_BIT     = 7;
    localparam int          SC_RANGE_BIT  = 6;
    localparam int          SC_CUR_LO     = 2;
    localparam int          SC_OUT_BIT    = 1;
    localparam int          SC_PICK_BIT   = 0;
    localparam int          OPT_FTSRC_BIT = 0;
    localparam int          ST_SRC_LO     = 6;
    localparam int          ST_GSRC_BIT   = 2;
    localparam int          ST_GE_BIT     = 1;
    localparam int          ST_ON_BIT     = 0;
    localparam int          IRQ_W         = 3;
    localparam int          IRQ_FT_OVF    = 0;
    localparam int          IRQ_ST_OVF    = 1;
    localparam int          IRQ_NOISE     = 2;
    localparam logic [7:0]  RST_SENSE_CTL = 8'h00;
    localparam logic [7:0]  RST_ST_CTL    = 8'h00;
    localparam logic [2:0]  RST_IRQ       = 3'h0;

    // ****************************************************************
    // Encodings
    // ****************************************************************
    localparam logic [1:0]  CUR_ZERO      = 2'h0;
    localparam logic [1:0]  CUR_LOW       = 2'h1;
    localparam logic [1:0]  CUR_MED       = 2'h2;
    localparam logic [1:0]  CUR_HIGH      = 2'h3;
    localparam logic [1:0]  ST_SRC_CORE   = 2'h0;
    localparam logic [1:0]  ST_SRC_CORE2  = 2'h1;
    localparam logic [1:0]  ST_SRC_PIN    = 2'h2;
    localparam logic [1:0]  ST_SRC_SENSE  = 2'h3;

    typedef enum logic [2:0] {
        PM_OFF   = 3'h0,
        PM_NOISE = 3'h1,
        PM_LOW   = 3'h2,
        PM_MED   = 3'h3,
        PM_HIGH  = 3'h4
    } cst_power_mode_t;

    typedef enum logic {LO_REF_GND = 1'b0, LO_REF_DAC = 1'b1} cst_lo_ref_t;
    typedef enum logic {HI_REF_VDD = 1'b0, HI_REF_FVR = 1'b1} cst_hi_ref_t;

    // Controls handed to the analog oscillator
    typedef struct packed {
        cst_hi_ref_t upper_ref;
        cst_lo_ref_t lower_ref;
        logic        source_en;
        logic        sink_en;
        logic        cmp_en;
        logic        range_high;
        logic [1:0]  level;
    } cst_analog_t;

    // Decode of range bit and current field into a power mode
    function automatic cst_power_mode_t cst_mode(input logic range_high, input logic [1:0] cur);
        cst_power_mode_t m;
        m = PM_OFF;
        unique case (cur)
            CUR_ZERO: m = range_high ? PM_NOISE : PM_OFF;
            CUR_LOW:  m = PM_LOW;
            CUR_MED:  m = PM_MED;
            CUR_HIGH: m = PM_HIGH;
        endcase
        return m;
    endfunction : cst_mode

endpackage : cst_pkg

// Oscillator control: reference and current steering, comparator edge pick-up
module cst_osc_ctl
    import cst_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Settings
    input  wire logic        enable,
    input  wire logic        range_high,
    input  wire logic [1:0]  cur,
    // Comparator from the analog oscillator
    input  wire logic        cmp_in,
    // Results
    output cst_analog_t      analog,
    output logic             osc_level,
    output logic             sense_edge,
    output logic             noise_mode
);

    cst_analog_t     analog_q;
    cst_analog_t     analog_d;
    logic            cmp_q;
    cst_power_mode_t mode;

    assign mode = cst_mode(range_high, cur);

    // ****************************************************************
    // Analog steering, follows the settings with no hold-off
    // ****************************************************************
    always_comb begin
        analog_d            = '0;
        analog_d.range_high = range_high;
        analog_d.level      = cur;
        analog_d.lower_ref  = range_high ? LO_REF_DAC : LO_REF_GND;
        analog_d.upper_ref  = range_high ? HI_REF_FVR : HI_REF_VDD;
        // Comparators stay on in noise mode; only the pin drive stops
        analog_d.cmp_en     = enable && (mode != PM_OFF);
        analog_d.source_en  = enable && (mode != PM_OFF) && (mode != PM_NOISE);
        analog_d.sink_en    = analog_d.source_en;
    end

    // Registered so the analog side sees glitch-free controls
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            analog_q <= '0;
        end else begin
            analog_q <= analog_d;
        end
    end

    // Comparator sample for edge detection
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmp_q <= 1'b0;
        end else begin
            cmp_q <= cmp_in;
        end
    end

    assign analog     = analog_q;
    assign osc_level  = cmp_q;
    // Rising comparator edge is one oscillator cycle, noise-driven or not
    assign sense_edge = enable && analog_q.cmp_en && cmp_in && !cmp_q;
    assign noise_mode = enable && (mode == PM_NOISE);

endmodule : cst_osc_ctl

// file: cst_pad_model.sv
// Behavioural sense pad with its oscillator comparator
`timescale 1ns/1ns
module cst_pad_model
    import cst_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Controls and pad stimulus
    input  wire cst_analog_t analog,
    input  wire logic        run,
    input  wire logic        noise,
    input  wire logic        load,
    // Comparator
    output logic             cmp_in
);
    logic [2:0] phase_q;
    // Threshold crossings every two cycles while current flows; the phase is not
    // cleared on a mode change, so a change acts at once
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase_q <= 3'h0;
            cmp_in  <= 1'b0;
        end else if (!run || !analog.cmp_en) begin
            cmp_in <= 1'b0; // Quiet pad or dead comparator reads low
        end else if (analog.source_en && analog.sink_en) begin
            // An added load halves the oscillation rate
            phase_q <= phase_q + 3'h1;
            cmp_in  <= load ? phase_q[2] : phase_q[1];
        end else begin
            cmp_in <= noise; // No drive: only pad noise moves it
        end
    end
endmodule : cst_pad_model

// file: cst_top.sv
// Capacitive sense range control, timers and Wishbone register slave
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ns

module cst_top
    import cst_pkg::*;
#(
    parameter int FT_W = 8,
    parameter int ST_W = 16
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // Wishbone classic slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [ADDR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // Analog oscillator
    input  wire logic                cmp_in,
    output cst_analog_t              analog,
    // Timer pins
    input  wire logic                ft_pin_clk,
    input  wire logic                st_pin_clk,
    input  wire logic                st_gate_in,
    // Interrupt
    output logic                     irq
);

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [7:0]       sense_ctl_q;
    logic             ft_src_q;
    logic [7:0]       st_ctl_q;
    logic [FT_W-1:0]  ft_cnt_q;
    logic [ST_W-1:0]  st_cnt_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic             ack_q;
    logic [31:0]      dat_q;
    logic             ft_pin_q;
    logic             st_pin_q;
    logic             gate_tgl_q;

    logic             sense_edge;
    logic             osc_level;
    logic             noise_mode;
    logic             req;
    logic             wr_now;
    logic             rd_now;
    logic [31:0]      rd_data;
    logic             ft_tick;
    logic             ft_ovf;
    logic             st_tick;
    logic             st_run;
    logic             st_gate_ok;
    logic             st_ovf;
    logic [IRQ_W-1:0] irq_events;
    logic [1:0]       st_src;

    // ****************************************************************
    // Oscillator control
    // ****************************************************************
    cst_osc_ctl u_osc (
        .core_clk   (core_clk),
        .rst        (rst),
        .enable     (sense_ctl_q[SC_EN_BIT]),
        .range_high (sense_ctl_q[SC_RANGE_BIT]),
        .cur        (sense_ctl_q[SC_CUR_LO+1:SC_CUR_LO]),
        .cmp_in     (cmp_in),
        .analog     (analog),
        .osc_level  (osc_level),
        .sense_edge (sense_edge),
        .noise_mode (noise_mode)
    );

    // ****************************************************************
    // Wishbone handshake
    // ****************************************************************
    // Request seen, ack one cycle later; the write lands on the ack edge
    assign req    = wb_cyc_i && wb_stb_i;
    assign wr_now = req && ack_q && wb_we_i;
    assign rd_now = req && ack_q && !wb_we_i;

    // Ack pulses once per request and drops the cycle after
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    // Read mux; unmapped offsets read zero and are still acknowledged
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (wb_adr_i)
            OFF_SENSE_CTL: begin
                rd_data[7:0]      = sense_ctl_q;
                rd_data[SC_OUT_BIT] = osc_level;
            end
            OFF_OPTION:   rd_data[OPT_FTSRC_BIT] = ft_src_q;
            OFF_ST_CTL:   rd_data[7:0] = st_ctl_q;
            OFF_FT_CNT:   rd_data[FT_W-1:0] = ft_cnt_q;
            OFF_ST_CNT:   rd_data[ST_W-1:0] = st_cnt_q;
            // Events of the capture edge are reported, since the clear follows
            OFF_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_stat_q | irq_events;
            OFF_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask_q;
            OFF_ANALOG:   rd_data[7:0] = analog;
            default:      rd_data = 32'h0000_0000;
        endcase
    end

    // Read data captured as ack rises and held while ack is high
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dat_q <= 32'h0000_0000;
        end else if (req && !ack_q) begin
            dat_q <= rd_data;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ****************************************************************
    // Control registers
    // ****************************************************************
    // Range and current changes act at once; the timers keep their count
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sense_ctl_q <= RST_SENSE_CTL;
        end else if (wr_now && wb_adr_i == OFF_SENSE_CTL && wb_sel_i[0]) begin
            sense_ctl_q <= wb_dat_i[7:0] & 8'hcd;
        end
    end

    // First timer clock source bit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ft_src_q <= 1'b0;
        end else if (wr_now && wb_adr_i == OFF_OPTION && wb_sel_i[0]) begin
            ft_src_q <= wb_dat_i[OPT_FTSRC_BIT];
        end
    end

    // Second timer control
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_ctl_q <= RST_ST_CTL;
        end else if (wr_now && wb_adr_i == OFF_ST_CTL && wb_sel_i[0]) begin
            st_ctl_q <= wb_dat_i[7:0] & 8'hc7;
        end
    end

    // Interrupt mask
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_mask_q <= RST_IRQ;
        end else if (wr_now && wb_adr_i == OFF_IRQ_MASK && wb_sel_i[0]) begin
            irq_mask_q <= wb_dat_i[IRQ_W-1:0];
        end
    end

    // ****************************************************************
    // First timer
    // ****************************************************************
    // Pin sample for edge detection
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ft_pin_q <= 1'b0;
            st_pin_q <= 1'b0;
        end else begin
            ft_pin_q <= ft_pin_clk;
            st_pin_q <= st_pin_clk;
        end
    end

    // Source bit set counts core cycles; clear takes the external clock,
    // which is the oscillator when the pick bit is set
    always_comb begin
        if (ft_src_q) begin
            ft_tick = 1'b1;
        end else if (sense_ctl_q[SC_PICK_BIT]) begin
            ft_tick = sense_edge;
        end else begin
            ft_tick = ft_pin_clk && !ft_pin_q;
        end
    end

    assign ft_ovf = ft_tick && (ft_cnt_q == {FT_W{1'b1}});

    // A bus write loads the count; software clears it to start a window
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ft_cnt_q <= '0;
        end else if (wr_now && wb_adr_i == OFF_FT_CNT && wb_sel_i[0]) begin
            ft_cnt_q <= wb_dat_i[FT_W-1:0];
        end else if (ft_tick) begin
            ft_cnt_q <= ft_cnt_q + 1'b1;
        end
    end

    // ****************************************************************
    // Second timer with gate
    // ****************************************************************
    assign st_src = st_ctl_q[ST_SRC_LO+1:ST_SRC_LO];

    // Tick source selection
    always_comb begin
        unique case (st_src)
            ST_SRC_CORE, ST_SRC_CORE2: st_tick = 1'b1;
            ST_SRC_PIN:                st_tick = st_pin_clk && !st_pin_q;
            ST_SRC_SENSE:              st_tick = sense_edge;
        endcase
    end

    // Toggle gate flips on each first timer overflow while gate enable is set, which gives a
    // fixed window when the first timer counts core cycles and not the oscillator
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gate_tgl_q <= 1'b0;
        end else if (!st_ctl_q[ST_GE_BIT]) begin
            gate_tgl_q <= 1'b0;
        end else if (ft_ovf) begin
            gate_tgl_q <= !gate_tgl_q;
        end
    end

    assign st_gate_ok = st_ctl_q[ST_GSRC_BIT] ? gate_tgl_q : st_gate_in;
    // Off, free running, or counting only while the gate permits
    assign st_run     = st_ctl_q[ST_ON_BIT] && (!st_ctl_q[ST_GE_BIT] || st_gate_ok);
    assign st_ovf     = st_run && st_tick && (st_cnt_q == {ST_W{1'b1}});

    // Byte lanes 0 and 1 load the low and high halves separately
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_cnt_q <= '0;
        end else if (wr_now && wb_adr_i == OFF_ST_CNT && (wb_sel_i[0] || wb_sel_i[1])) begin
            if (wb_sel_i[0]) begin
                st_cnt_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                st_cnt_q[ST_W-1:8] <= wb_dat_i[ST_W-1:8];
            end
        end else if (st_run && st_tick) begin
            st_cnt_q <= st_cnt_q + 1'b1;
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    always_comb begin
        irq_events             = '0;
        irq_events[IRQ_FT_OVF] = ft_ovf;
        irq_events[IRQ_ST_OVF] = st_ovf;
        irq_events[IRQ_NOISE]  = noise_mode && sense_edge;
    end

    // Read clears, but an event in the same cycle survives the clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= RST_IRQ;
        end else if (rd_now && wb_adr_i == OFF_IRQ_STAT) begin
            irq_stat_q <= irq_events;
        end else begin
            irq_stat_q <= irq_stat_q | irq_events;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

endmodule : cst_top
